// ### design/frs_pkg.sv
package frs_pkg;

   // -----------------------------------------------------------------
   // Frequency types, all in 0.01 Hz or 0.1 Hz steps per decimal select
   // -----------------------------------------------------------------
   typedef logic [15:0]        frs_freq_t;
   typedef logic signed [19:0] frs_sfreq_t;

   // -----------------------------------------------------------------
   // Control word layout, most significant field first
   // -----------------------------------------------------------------
   typedef struct packed {
      logic       ramp_ref;      // ramp_reference_select
      logic [1:0] below_act;     // below_min_action
      logic [2:0] ul_src;        // upper_limit_source
      logic [1:0] dec_sel;       // freq_decimal_select
      logic [1:0] time_unit;     // ramp_time_unit
      logic       derate_en;     // carrier_thermal_derate
      logic       dir_inv;       // direction_invert
      logic       range_ref;     // aux_range_ref_select
      logic [1:0] tens;          // channel_combine_select, tens digit
      logic [3:0] ones;          // channel_combine_select, ones digit
   } frs_ctrl_t;

   localparam int CTRL_W = $bits(frs_ctrl_t);

   typedef enum logic [1:0] {BELOW_STOP, BELOW_RUN_LOWER, BELOW_ZERO} frs_below_t;

   // -----------------------------------------------------------------
   // Register byte addresses
   // -----------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL      = 8'h00;
   localparam logic [7:0] ADDR_AUX_GAIN  = 8'h04;
   localparam logic [7:0] ADDR_PRESET    = 8'h08;
   localparam logic [7:0] ADDR_MAX_FREQ  = 8'h0C;
   localparam logic [7:0] ADDR_UL_VALUE  = 8'h10;
   localparam logic [7:0] ADDR_UL_BIAS   = 8'h14;
   localparam logic [7:0] ADDR_LOWER     = 8'h18;
   localparam logic [7:0] ADDR_CARRIER   = 8'h1C;
   localparam logic [7:0] ADDR_ACCEL     = 8'h20;
   localparam logic [7:0] ADDR_DECEL     = 8'h24;
   localparam logic [7:0] ADDR_CMB_BIAS  = 8'h28;
   localparam logic [7:0] ADDR_STATUS    = 8'h2C;
   localparam logic [7:0] ADDR_CARR_ACT  = 8'h30;

   // -----------------------------------------------------------------
   // Reset values and limits
   // -----------------------------------------------------------------
   localparam frs_ctrl_t CTRL_RST = '{ramp_ref: 1'b0, below_act: 2'h0, ul_src: 3'h0,
                                     dec_sel: 2'h2, time_unit: 2'h1, derate_en: 1'b1,
                                     dir_inv: 1'b0, range_ref: 1'b1, tens: 2'h0,
                                     ones: 4'h0};
   localparam logic [7:0]  GAIN_RST     = 8'h64;      // 100 %
   localparam logic [7:0]  GAIN_MAX     = 8'h96;      // 150 %
   localparam frs_freq_t   PRESET_RST   = 16'h1388;   // 50.00 Hz
   localparam frs_freq_t   MAX_RST      = 16'h1388;   // 50.00 Hz
   localparam frs_freq_t   UL_RST       = 16'h1388;   // 50.00 Hz
   localparam frs_freq_t   CAP_DEC1     = 16'h7D00;   // 3200.0 Hz
   localparam frs_freq_t   CAP_DEC2     = 16'hC350;   // 500.00 Hz
   localparam logic [7:0]  CARRIER_MIN  = 8'h05;      // 0.5 kHz
   localparam logic [7:0]  CARRIER_MAX  = 8'hA0;      // 16.0 kHz
   localparam logic [10:0] PCT_FULL     = 11'h3E8;    // 100.0 % in 0.1 %
   localparam logic [2:0]  UL_SRC_MAX   = 3'h5;

   // -----------------------------------------------------------------
   // Timing of carrier derating steps
   // -----------------------------------------------------------------
   localparam int CLK_KHZ          = 100000;
   localparam int DERATE_STEP_MS   = 100;
   localparam int RECOVER_STEP_MS  = 500;
   localparam int DERATE_STEP_CYC  = DERATE_STEP_MS * CLK_KHZ;
   localparam int RECOVER_STEP_CYC = RECOVER_STEP_MS * CLK_KHZ;

endpackage

// ### design/frs_selector.sv
// Overview of operation
// - Analog or pulse 100% auxiliary input maps to the full auxiliary range.
// - Range reference picks maximum frequency or main channel; reset value one.
// - Auxiliary range scaled by gain 0 to 150 percent, reset 100.
// - Range reference and gain apply only in combine modes 1, 3, 4.
// - Ones digit 0 selects main channel X alone.
// - Ones digit 1 selects arithmetic result; tens digit picks the operation.
// - Ones digit 2: X when switch input inactive, Y when active.
// - Ones digit 3: X when switch inactive, arithmetic result when active.
// - Ones digit 4: Y when switch inactive, arithmetic result when active.
// - Tens digit 0 makes the arithmetic result X plus Y.
// - Tens digit 1 makes the arithmetic result X minus Y.
// - Tens 2 takes larger absolute value, tens 3 the smaller.
// - A bias frequency is added whenever the arithmetic result is used.
// - Digital preset, default 50.00 Hz, gives the initial set frequency.
// - One-bit direction setting reverses motor rotation.
// - Analog 100.0 percent scales to maximum frequency, default 50.00 Hz.
// - Decimal select 1 caps at 3200.0 Hz, 2 caps at 500.00 Hz.
// - Upper limit from digital value or analog; analog 100% equals digital value.
// - Below lower limit: stop, run at lower limit, or zero speed.
// - Carrier 0.5 to 16.0 kHz, derated when hot, recovered gradually.
// - Accel and decel times 0 to 65000 between zero and ramp reference; the registers keep any written value up to 65535.
// - Ramp time unit 0 to 2 selects 1 s, 0.1 s or 0.01 s.
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module frs_selector
   import frs_pkg::*;
#(
   parameter int DERATE_CYC  = DERATE_STEP_CYC,
   parameter int RECOVER_CYC = RECOVER_STEP_CYC,
   parameter logic [7:0]  CARRIER_RST = 8'h3C,   // Model dependent, 6.0 kHz
   parameter logic [15:0] ACCEL_RST   = 16'h00C8,
   parameter logic [15:0] DECEL_RST   = 16'h00C8
) (
   // Clock, reset, enable
   input  wire logic              CLOCK_IN,
   input  wire logic              SYS_RST_IN,
   input  wire logic              CLK_EN_IN,
   // APB slave
   input  wire logic              PSEL_IN,
   input  wire logic              PENABLE_IN,
   input  wire logic              PWRITE_IN,
   input  wire logic [7:0]        PADDR_IN,
   input  wire logic [31:0]       PWDATA_IN,
   output logic [31:0]            PRDATA_OUT,
   output logic                   PREADY_OUT,
   output logic                   PSLVERR_OUT,
   // Channel inputs
   input  wire logic signed [17:0] MAIN_FREQ_IN,
   input  wire logic              AUX_IS_PCT_IN,
   input  wire logic [10:0]       AUX_PCT_IN,
   input  wire logic signed [17:0] AUX_FREQ_IN,
   input  wire logic              FREQ_SWITCH_IN,
   input  wire logic [10:0]       ANALOG_IN_FIRST_IN,
   input  wire logic [10:0]       ANALOG_IN_SECOND_IN,
   input  wire logic [10:0]       UL_EXT_PCT_IN,
   input  wire logic              HEATSINK_HOT_IN,
   // Results toward ramp and modulation
   output logic [15:0]            TARGET_FREQ_OUT,
   output logic                   DIR_REVERSE_OUT,
   output logic                   RUN_ALLOW_OUT,
   output logic                   BELOW_MIN_OUT,
   output logic [15:0]            PRESET_FREQ_OUT,
   output logic [7:0]             CARRIER_OUT,
   output logic [15:0]            ACCEL_TIME_OUT,
   output logic [15:0]            DECEL_TIME_OUT,
   output logic [1:0]             RAMP_UNIT_OUT,
   output logic [15:0]            RAMP_REF_FREQ_OUT
);

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   frs_ctrl_t   ctrl_ff;
   logic [7:0]  gain_ff;
   frs_freq_t   preset_ff, max_ff, ul_val_ff, ul_bias_ff, lower_ff, cmb_bias_ff;
   logic [7:0]  carr_set_ff;
   logic [15:0] accel_ff, decel_ff;
   logic        apb_req, apb_fire;
   frs_ctrl_t   wr_ctrl;

   assign apb_req  = PSEL_IN & PENABLE_IN;
   assign apb_fire = apb_req & PREADY_OUT;
   assign wr_ctrl  = PWDATA_IN[CTRL_W-1:0];

   // Writes land at the edge where pready is sampled high
   always_ff @(posedge CLOCK_IN) begin
      if (SYS_RST_IN) begin
         ctrl_ff     <= CTRL_RST;
         gain_ff     <= GAIN_RST;
         preset_ff   <= PRESET_RST;
         max_ff      <= MAX_RST;
         ul_val_ff   <= UL_RST;
         ul_bias_ff  <= '0;
         lower_ff    <= '0;
         carr_set_ff <= CARRIER_RST;
         accel_ff    <= ACCEL_RST;
         decel_ff    <= DECEL_RST;
         cmb_bias_ff <= '0;
      end else if (CLK_EN_IN && apb_fire && PWRITE_IN) begin
         case (PADDR_IN)
            ADDR_CTRL: begin
               ctrl_ff <= wr_ctrl;
               // Out-of-range limit source falls back to digital
               if (wr_ctrl.ul_src > UL_SRC_MAX) begin
                  ctrl_ff.ul_src <= '0;
               end
            end
            // Gain saturates rather than wraps
            ADDR_AUX_GAIN: gain_ff <= (PWDATA_IN[7:0] > GAIN_MAX) ? GAIN_MAX : PWDATA_IN[7:0];
            ADDR_PRESET:   preset_ff   <= PWDATA_IN[15:0];
            ADDR_MAX_FREQ: max_ff      <= PWDATA_IN[15:0];
            ADDR_UL_VALUE: ul_val_ff   <= PWDATA_IN[15:0];
            ADDR_UL_BIAS:  ul_bias_ff  <= PWDATA_IN[15:0];
            ADDR_LOWER:    lower_ff    <= PWDATA_IN[15:0];
            ADDR_CARRIER: begin
               if (PWDATA_IN[7:0] < CARRIER_MIN) begin
                  carr_set_ff <= CARRIER_MIN;
               end else if (PWDATA_IN[7:0] > CARRIER_MAX) begin
                  carr_set_ff <= CARRIER_MAX;
               end else begin
                  carr_set_ff <= PWDATA_IN[7:0];
               end
            end
            ADDR_ACCEL:    accel_ff    <= PWDATA_IN[15:0];
            ADDR_DECEL:    decel_ff    <= PWDATA_IN[15:0];
            ADDR_CMB_BIAS: cmb_bias_ff <= PWDATA_IN[15:0];
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // APB answer: one wait state, so every access takes three cycles
   // ----------------------------------------------------------------
   logic        hit;
   logic [31:0] rd_mux;

   always_comb begin
      hit    = 1'b1;
      rd_mux = 32'h0;
      case (PADDR_IN)
         ADDR_CTRL:     rd_mux = {{(32-CTRL_W){1'b0}}, ctrl_ff};
         ADDR_AUX_GAIN: rd_mux = {24'h0, gain_ff};
         ADDR_PRESET:   rd_mux = {16'h0, preset_ff};
         ADDR_MAX_FREQ: rd_mux = {16'h0, max_ff};
         ADDR_UL_VALUE: rd_mux = {16'h0, ul_val_ff};
         ADDR_UL_BIAS:  rd_mux = {16'h0, ul_bias_ff};
         ADDR_LOWER:    rd_mux = {16'h0, lower_ff};
         ADDR_CARRIER:  rd_mux = {24'h0, carr_set_ff};
         ADDR_ACCEL:    rd_mux = {16'h0, accel_ff};
         ADDR_DECEL:    rd_mux = {16'h0, decel_ff};
         ADDR_CMB_BIAS: rd_mux = {16'h0, cmb_bias_ff};
         ADDR_STATUS:   rd_mux = {13'h0, BELOW_MIN_OUT, RUN_ALLOW_OUT, DIR_REVERSE_OUT,
                                  TARGET_FREQ_OUT};
         ADDR_CARR_ACT: rd_mux = {24'h0, CARRIER_OUT};
         default:       hit    = 1'b0;
      endcase
   end

   // Pready pulses for one cycle in the second access cycle
   always_ff @(posedge CLOCK_IN) begin
      if (SYS_RST_IN) begin
         PREADY_OUT  <= 1'b0;
         PSLVERR_OUT <= 1'b0;
         PRDATA_OUT  <= 32'h0;
      end else if (CLK_EN_IN) begin
         PREADY_OUT  <= apb_req & ~PREADY_OUT;
         PSLVERR_OUT <= apb_req & ~PREADY_OUT & ~hit;
         PRDATA_OUT  <= (apb_req & ~PREADY_OUT & ~PWRITE_IN) ? rd_mux : 32'h0;
      end
   end

   // ----------------------------------------------------------------
   // Limits: maximum capped by resolution, upper limit from source
   // ----------------------------------------------------------------
   frs_freq_t   cap, max_eff, ul_raw;
   logic [10:0] ul_pct;
   logic [26:0] ul_prod;
   logic [16:0] ul_sum;

   assign cap     = (ctrl_ff.dec_sel == 2'h1) ? CAP_DEC1 : CAP_DEC2;
   assign max_eff = (max_ff > cap) ? cap : max_ff;
   assign ul_prod = ul_pct * ul_val_ff;

   always_comb begin
      case (ctrl_ff.ul_src)
         3'h1:    ul_pct = ANALOG_IN_FIRST_IN;
         3'h2:    ul_pct = ANALOG_IN_SECOND_IN;
         3'h3, 3'h4, 3'h5: ul_pct = UL_EXT_PCT_IN;
         default: ul_pct = PCT_FULL;
      endcase
      // Analog full scale equals the digital limit value
      ul_raw = (ul_src_analog(ctrl_ff.ul_src)) ? 16'(ul_prod / 27'(PCT_FULL)) : ul_val_ff;
      ul_sum = {1'b0, ul_raw} + {1'b0, ul_bias_ff};
   end

   function automatic logic ul_src_analog(input logic [2:0] s);
      ul_src_analog = (s != 3'h0);
   endfunction

   // ----------------------------------------------------------------
   // Stage 1: auxiliary channel scaling and upper limit
   // ----------------------------------------------------------------
   logic              arith_mode;
   frs_freq_t         x_abs, range_f;
   logic [34:0]       aux_prod_arith;
   logic [26:0]       aux_prod_max;
   frs_sfreq_t        x_ff, y_ff, y_nxt;
   frs_freq_t         upper_ff, max_eff_ff;

   function automatic frs_freq_t abs_f(input frs_sfreq_t v);
      abs_f = (v < 0) ? 16'(-v) : 16'(v);
   endfunction

   assign arith_mode = (ctrl_ff.ones == 4'h1) || (ctrl_ff.ones == 4'h3) ||
                       (ctrl_ff.ones == 4'h4);
   assign x_abs      = abs_f(20'(MAIN_FREQ_IN));
   // Range tracks main channel when referenced to it
   assign range_f    = ctrl_ff.range_ref ? x_abs : max_eff;
   assign aux_prod_arith = AUX_PCT_IN * range_f * gain_ff;
   assign aux_prod_max   = AUX_PCT_IN * max_eff;

   always_comb begin
      if (!AUX_IS_PCT_IN) begin
         y_nxt = 20'(AUX_FREQ_IN);
      end else if (arith_mode) begin
         // 100 % input times gain percent gives the full range
         y_nxt = 20'(aux_prod_arith / 35'd100000);
      end else begin
         y_nxt = 20'(aux_prod_max / 27'(PCT_FULL));
      end
   end

   always_ff @(posedge CLOCK_IN) begin
      if (SYS_RST_IN) begin
         x_ff       <= '0;
         y_ff       <= '0;
         upper_ff   <= '0;
         max_eff_ff <= MAX_RST;
      end else if (CLK_EN_IN) begin
         x_ff       <= 20'(MAIN_FREQ_IN);
         y_ff       <= y_nxt;
         max_eff_ff <= max_eff;
         upper_ff   <= (ul_sum > {1'b0, max_eff}) ? max_eff : ul_sum[15:0];
      end
   end

   // ----------------------------------------------------------------
   // Stage 2: arithmetic result and channel selection
   // ----------------------------------------------------------------
   frs_sfreq_t arith, sel_ff, sel_nxt;
   frs_freq_t  upper2_ff;

   always_comb begin
      case (ctrl_ff.tens)
         2'h0:    arith = x_ff + y_ff;
         2'h1:    arith = x_ff - y_ff;
         2'h2:    arith = (abs_f(x_ff) >= abs_f(y_ff)) ? x_ff : y_ff;
         default: arith = (abs_f(x_ff) <= abs_f(y_ff)) ? x_ff : y_ff;
      endcase
      arith = arith + $signed({4'h0, cmb_bias_ff});
      case (ctrl_ff.ones)
         4'h1:    sel_nxt = arith;
         4'h2:    sel_nxt = FREQ_SWITCH_IN ? y_ff : x_ff;
         4'h3:    sel_nxt = FREQ_SWITCH_IN ? arith : x_ff;
         4'h4:    sel_nxt = FREQ_SWITCH_IN ? arith : y_ff;
         default: sel_nxt = x_ff;
      endcase
   end

   always_ff @(posedge CLOCK_IN) begin
      if (SYS_RST_IN) begin
         sel_ff    <= '0;
         upper2_ff <= '0;
      end else if (CLK_EN_IN) begin
         sel_ff    <= sel_nxt;
         upper2_ff <= upper_ff;
      end
   end

   // ----------------------------------------------------------------
   // Stage 3: clamp, lower limit handling, direction
   // ----------------------------------------------------------------
   frs_freq_t mag, clamped;
   logic      below;

   assign mag     = (abs_f(sel_ff) > 20'(upper2_ff)) ? upper2_ff : abs_f(sel_ff);
   assign clamped = mag;
   assign below   = (clamped < lower_ff);

   always_ff @(posedge CLOCK_IN) begin
      if (SYS_RST_IN) begin
         TARGET_FREQ_OUT <= '0;
         RUN_ALLOW_OUT   <= 1'b0;
         BELOW_MIN_OUT   <= 1'b0;
         DIR_REVERSE_OUT <= 1'b0;
      end else if (CLK_EN_IN) begin
         BELOW_MIN_OUT   <= below;
         // Sign of the setting, flipped by the direction bit
         DIR_REVERSE_OUT <= (sel_ff < 0) ^ ctrl_ff.dir_inv;
         if (!below) begin
            TARGET_FREQ_OUT <= clamped;
            RUN_ALLOW_OUT   <= 1'b1;
         end else begin
            case (frs_below_t'(ctrl_ff.below_act))
               BELOW_RUN_LOWER: begin
                  TARGET_FREQ_OUT <= lower_ff;
                  RUN_ALLOW_OUT   <= 1'b1;
               end
               BELOW_ZERO: begin
                  TARGET_FREQ_OUT <= '0;
                  RUN_ALLOW_OUT   <= 1'b1;
               end
               default: begin
                  TARGET_FREQ_OUT <= '0;
                  RUN_ALLOW_OUT   <= 1'b0;
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Ramp settings toward the ramp generator
   // ----------------------------------------------------------------
   always_ff @(posedge CLOCK_IN) begin
      if (SYS_RST_IN) begin
         PRESET_FREQ_OUT   <= PRESET_RST;
         ACCEL_TIME_OUT    <= ACCEL_RST;
         DECEL_TIME_OUT    <= DECEL_RST;
         RAMP_UNIT_OUT     <= CTRL_RST.time_unit;
         RAMP_REF_FREQ_OUT <= MAX_RST;
      end else if (CLK_EN_IN) begin
         PRESET_FREQ_OUT   <= preset_ff;
         ACCEL_TIME_OUT    <= accel_ff;
         DECEL_TIME_OUT    <= decel_ff;
         // Code 3 is not a unit, so it reads as the reset unit
         RAMP_UNIT_OUT     <= (ctrl_ff.time_unit == 2'h3) ? CTRL_RST.time_unit
                                                         : ctrl_ff.time_unit;
         RAMP_REF_FREQ_OUT <= ctrl_ff.ramp_ref ? TARGET_FREQ_OUT : max_eff_ff;
      end
   end

   // ----------------------------------------------------------------
   // Carrier derating: one 0.1 kHz step per interval
   // ----------------------------------------------------------------
   logic [31:0] step_cnt_ff;
   logic        step_due;

   assign step_due = HEATSINK_HOT_IN ? (step_cnt_ff >= 32'(DERATE_CYC - 1))
                                     : (step_cnt_ff >= 32'(RECOVER_CYC - 1));

   // Slow recovery keeps the heatsink from cycling hot and cool
   always_ff @(posedge CLOCK_IN) begin
      if (SYS_RST_IN) begin
         CARRIER_OUT <= CARRIER_RST;
         step_cnt_ff <= '0;
      end else if (CLK_EN_IN) begin
         step_cnt_ff <= step_due ? 32'h0 : step_cnt_ff + 32'h1;
         if (!ctrl_ff.derate_en || CARRIER_OUT > carr_set_ff) begin
            CARRIER_OUT <= carr_set_ff;
            step_cnt_ff <= '0;
         end else if (step_due) begin
            if (HEATSINK_HOT_IN && CARRIER_OUT > CARRIER_MIN) begin
               CARRIER_OUT <= CARRIER_OUT - 8'h01;
            end else if (!HEATSINK_HOT_IN && CARRIER_OUT < carr_set_ff) begin
               CARRIER_OUT <= CARRIER_OUT + 8'h01;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLOCK_IN); endclocking
   default disable iff (SYS_RST_IN);

   a_gain_bound: assert property (gain_ff <= GAIN_MAX)
      else $error("aux gain above 150 percent");
   a_carrier_span: assert property (CARRIER_OUT >= CARRIER_MIN && CARRIER_OUT <= CARRIER_MAX)
      else $error("carrier outside 0.5 to 16.0 kHz");
   a_mode_x_only: assert property (CLK_EN_IN && ctrl_ff.ones == 4'h0 |=> sel_ff == $past(x_ff))
      else $error("mode 0 did not pass main channel");
   a_switch_to_y: assert property (CLK_EN_IN && ctrl_ff.ones == 4'h2 && FREQ_SWITCH_IN
                                   |=> sel_ff == $past(y_ff))
      else $error("switch active did not select aux channel");
   a_sum_bias: assert property (CLK_EN_IN && ctrl_ff.ones == 4'h1 && ctrl_ff.tens == 2'h0
                                |=> sel_ff == $past(x_ff) + $past(y_ff)
                                              + $signed({4'h0, $past(cmb_bias_ff)}))
      else $error("sum mode result or bias wrong");
   a_target_ceiling: assert property (CLK_EN_IN ##1 CLK_EN_IN
                                      |=> TARGET_FREQ_OUT <= $past(upper_ff, 2)
                                          || TARGET_FREQ_OUT == $past(lower_ff))
      else $error("target above upper limit");
   a_below_stop: assert property (CLK_EN_IN && below && ctrl_ff.below_act == 2'h0
                                  |=> !RUN_ALLOW_OUT && TARGET_FREQ_OUT == 16'h0)
      else $error("below minimum did not stop");
   a_dir_invert: assert property (CLK_EN_IN |=> DIR_REVERSE_OUT
                                  == (($past(sel_ff) < 0) ^ $past(ctrl_ff.dir_inv)))
      else $error("direction bit not applied");
   a_pready_pulse: assert property (PREADY_OUT |=> !PREADY_OUT || !$past(CLK_EN_IN))
      else $error("pready held longer than one cycle");

   c_switch_y: cover property (ctrl_ff.ones == 4'h2 && FREQ_SWITCH_IN);
   c_below_min: cover property (BELOW_MIN_OUT && RUN_ALLOW_OUT);
   c_derated: cover property (CARRIER_OUT < carr_set_ff);
   c_apb_write: cover property (apb_fire && PWRITE_IN && hit);

endmodule

`default_nettype wire

// ### verification/frequency_reference_selector_test.sv
`timescale 1ns/10ps
`default_nettype none
`define CK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin n_fail++; \
   $display("unexpected %s exp %0h got %0h", nm, ex, gt); end end
module frequency_reference_selector_test;
   import frs_pkg::*;
   // Bench signals carry the port names, so the instance binds by name
   logic CLOCK_IN = 1'b0, SYS_RST_IN = 1'b1, CLK_EN_IN = 1'b1, PSEL_IN = 1'b0;
   logic PENABLE_IN = 1'b0, PWRITE_IN = 1'b0, AUX_IS_PCT_IN = 1'b0, FREQ_SWITCH_IN = 1'b0;
   logic HEATSINK_HOT_IN = 1'b0, PREADY_OUT, PSLVERR_OUT, er, DIR_REVERSE_OUT, RUN_ALLOW_OUT;
   logic BELOW_MIN_OUT;
   logic [1:0] RAMP_UNIT_OUT;
   logic [7:0] PADDR_IN = 8'h00, CARRIER_OUT;
   logic [10:0] AUX_PCT_IN = 11'h000, ANALOG_IN_FIRST_IN = 11'h000;
   logic [10:0] ANALOG_IN_SECOND_IN = 11'h000, UL_EXT_PCT_IN = 11'h000;
   logic signed [17:0] MAIN_FREQ_IN = 18'sh00000, AUX_FREQ_IN = 18'sh00000;
   logic [31:0] PWDATA_IN = 32'h0000_0000, PRDATA_OUT, rd;
   logic [15:0] TARGET_FREQ_OUT, PRESET_FREQ_OUT, ACCEL_TIME_OUT, DECEL_TIME_OUT;
   logic [15:0] RAMP_REF_FREQ_OUT;
   int n_fail = 0;
   int n_checks = 0;

   frs_selector #(.DERATE_CYC(8), .RECOVER_CYC(16)) u_dut (.CLOCK_IN, .SYS_RST_IN,
      .CLK_EN_IN, .PSEL_IN, .PENABLE_IN, .PWRITE_IN, .PADDR_IN, .PWDATA_IN, .PRDATA_OUT,
      .PREADY_OUT, .PSLVERR_OUT, .MAIN_FREQ_IN, .AUX_IS_PCT_IN, .AUX_PCT_IN, .AUX_FREQ_IN,
      .FREQ_SWITCH_IN, .ANALOG_IN_FIRST_IN, .ANALOG_IN_SECOND_IN, .UL_EXT_PCT_IN,
      .HEATSINK_HOT_IN, .TARGET_FREQ_OUT, .DIR_REVERSE_OUT, .RUN_ALLOW_OUT, .BELOW_MIN_OUT,
      .PRESET_FREQ_OUT, .CARRIER_OUT, .ACCEL_TIME_OUT, .DECEL_TIME_OUT, .RAMP_UNIT_OUT,
      .RAMP_REF_FREQ_OUT);
   // 100 MHz clock
   initial forever #5 CLOCK_IN = ~CLOCK_IN;
   // Verdict, also reached when a wait runs out
   task automatic results;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // One APB transfer; an idle cycle first keeps each strobe to one change per step
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge CLOCK_IN);
      PSEL_IN <= 1'b1;
      PWRITE_IN <= w;
      PADDR_IN <= a;
      PWDATA_IN <= d;
      @(posedge CLOCK_IN);
      PENABLE_IN <= 1'b1;
      // Look mid-cycle, where the registered answer has settled
      for (n = 0; n < 20; n++) begin
         @(negedge CLOCK_IN);
         if (PREADY_OUT === 1'b1) break;
      end
      n_fail += (n == 20);
      if (n == 20) results();
      rd = PRDATA_OUT;
      er = PSLVERR_OUT;
      // Release only after the edge that samples pready high
      @(posedge CLOCK_IN);
      PSEL_IN <= 1'b0;
      PENABLE_IN <= 1'b0;
   endtask
   // Control word and channels, then six edges for the three-stage pipe
   task automatic cfg(input logic [31:0] c, input int x, input int y, input logic sw);
      bus(1'b1, ADDR_CTRL, c);
      MAIN_FREQ_IN <= 18'(x);
      AUX_FREQ_IN <= 18'(y);
      FREQ_SWITCH_IN <= sw;
      repeat (6) @(posedge CLOCK_IN);
   endtask
   // Reset values, refusals, every combine mode with X 1000 and Y 300
   task automatic t_basic;
      int t[11][4] = '{'{0,0,1,1000}, '{1,0,0,1300}, '{1,1,0,700}, '{1,2,0,1000},
         '{1,3,0,300}, '{2,0,0,1000}, '{2,0,1,300}, '{3,1,1,700}, '{3,0,0,1000},
         '{4,0,0,300}, '{4,2,1,1000}};
      `CK("preset", 16'h1388, PRESET_FREQ_OUT)
      `CK("ramp unit", 2'h1, RAMP_UNIT_OUT)
      `CK("accel", 16'h00C8, ACCEL_TIME_OUT)
      `CK("decel", 16'h00C8, DECEL_TIME_OUT)
      `CK("ramp ref", 16'h1388, RAMP_REF_FREQ_OUT)
      `CK("carrier", 8'h3C, CARRIER_OUT)
      bus(1'b0, ADDR_CTRL, 32'h0000_0000);
      `CK("ctrl", 32'h0000_1340, rd)
      bus(1'b1, ADDR_AUX_GAIN, 32'h0000_00C8);
      bus(1'b0, ADDR_AUX_GAIN, 32'h0000_0000);
      `CK("gain", 32'h0000_0096, rd)
      bus(1'b0, 8'hFC, 32'h0000_0000);
      `CK("unmapped", 1'b1, er)
      foreach (t[i]) begin
         cfg(32'h0000_1340 | 32'(t[i][1] << 4) | 32'(t[i][0]), 1000, 300, t[i][2][0]);
         `CK("mode", 16'(t[i][3]), TARGET_FREQ_OUT)
      end
      $display("basic test done");
   endtask
   // Percent path with gain, bias, clamps, direction and lower limit
   task automatic t_limits;
      bus(1'b1, ADDR_AUX_GAIN, 32'h0000_0032);
      AUX_IS_PCT_IN <= 1'b1;
      AUX_PCT_IN <= 11'h3E8;
      cfg(32'h0000_1301, 0, 0, 1'b0);
      `CK("aux gain", 16'h09C4, TARGET_FREQ_OUT)
      cfg(32'h0000_1342, 0, 0, 1'b1);
      `CK("no gain", 16'h1388, TARGET_FREQ_OUT)
      AUX_IS_PCT_IN <= 1'b0;
      bus(1'b1, ADDR_CMB_BIAS, 32'h0000_0032);
      cfg(32'h0000_1341, 1000, 300, 1'b0);
      `CK("bias", 16'h0546, TARGET_FREQ_OUT)
      cfg(32'h0000_1353, 1000, 300, 1'b1);
      `CK("bias switched", 16'h02EE, TARGET_FREQ_OUT)
      cfg(32'h0000_13C0, 6000, 0, 1'b0);
      `CK("clamp", 16'h1388, TARGET_FREQ_OUT)
      `CK("direction", 1'b1, DIR_REVERSE_OUT)
      bus(1'b1, ADDR_UL_VALUE, 32'h0000_07D0);
      bus(1'b1, ADDR_LOWER, 32'h0000_05DC);
      cfg(32'h0000_1340, 1000, 0, 1'b0);
      `CK("stopped", 1'b0, RUN_ALLOW_OUT)
      `CK("below flag", 1'b1, BELOW_MIN_OUT)
      cfg(32'h0001_1340, 3000, 0, 1'b0);
      `CK("upper", 16'h07D0, TARGET_FREQ_OUT)
      // Hot heatsink steps the carrier down every few cycles in sim
      HEATSINK_HOT_IN <= 1'b1;
      repeat (20) @(posedge CLOCK_IN);
      `CK("derate", 1'b1, CARRIER_OUT < 8'h3C)
      $display("limits test done");
   endtask
   // Reset held 20 cycles, then the scenarios
   initial begin
      repeat (20) @(posedge CLOCK_IN);
      SYS_RST_IN <= 1'b0;
      t_basic();
      t_limits();
      results();
   end
endmodule
`default_nettype wire
